/* File: common/aiw_defines.vh */
// register map, field positions, reset values and timing counts of the
// accelerometer interrupt and wake-up logic.
// assumes a 20 MHz core clock and an 8-bit register port from the serial bus.
`ifndef AIW_DEFINES_VH
`define AIW_DEFINES_VH

// register addresses
`define AIW_A_SRC_ONE     8'h16
`define AIW_A_SRC_TWO     8'h17
`define AIW_A_STATUS      8'h18
`define AIW_A_REL         8'h1A
`define AIW_A_CTRL_ONE    8'h1B
`define AIW_A_CTRL_TWO    8'h1D
`define AIW_A_PIN_CTL     8'h1E
`define AIW_A_MASK_CTL    8'h1F
`define AIW_A_TIMER       8'h29
`define AIW_A_INACT       8'h2B
`define AIW_A_THR_HI      8'h6A
`define AIW_A_THR_LO      8'h6B

// reset values
`define AIW_R_CTRL_ONE    8'h00
`define AIW_R_CTRL_TWO    8'h00
`define AIW_R_PIN_CTL     8'h10
`define AIW_R_MASK_CTL    8'h3F
`define AIW_R_TIMER       8'h00
`define AIW_R_INACT       8'h00
`define AIW_R_THR         12'h000

// field positions
`define AIW_B_DRDY_EN     5
`define AIW_B_WAKE_EN     1
`define AIW_B_PIN_EN      5
`define AIW_B_POL         4
`define AIW_B_PULSE       3
`define AIW_B_UNLATCH     7
`define AIW_B_PEND        4
`define AIW_B_SRC_DRDY    4
`define AIW_B_SRC_WAKE    1
`define AIW_F_RATE        2:0
`define AIW_F_MASK        5:0
`define AIW_RATE_MAX      3'h7

// timing
`define AIW_CLK_NS        50
`define AIW_PULSE_NS      40000
`define AIW_PULSE_CYC     (`AIW_PULSE_NS / `AIW_CLK_NS)
`define AIW_MOTION_BASE   200000

`endif

/* File: hdl/aiw_interrupt_wakeup.v */
// interrupt and wake-up logic: data-ready and motion sources onto one pin.
// assumes register strobes and acceleration samples arrive on ref_clk_in,
// already decoded by the serial bus slave and the sensing front end.
`timescale 1ns/1ns
`include "aiw_defines.vh"

module aiw_interrupt_wakeup #(
  parameter MOTION_BASE_CYCLES = `AIW_MOTION_BASE
) (
  // clock and reset
  input  wire              ref_clk_in,
  input  wire              rst_b_in,
  // register port
  input  wire [7:0]        reg_addr_in,
  input  wire [7:0]        reg_wdata_in,
  input  wire              reg_wr_in,
  input  wire              reg_rd_in,
  output reg  [7:0]        reg_rdata_out,
  // acceleration samples
  input  wire [11:0]       accel_x_in,
  input  wire [11:0]       accel_y_in,
  input  wire [11:0]       accel_z_in,
  input  wire              sample_valid_in,
  input  wire              accel_data_read_in,
  // interrupt pin
  output reg               int_pin_out
);

  // mode codes of the motion engine
  localparam ST_IDLE   = 1'b0;
  localparam ST_ACTIVE = 1'b1;

  // registers
  reg [7:0]  main_control_one_q;
  reg [7:0]  main_control_two_q;
  reg [7:0]  pin_interrupt_control_q;
  reg [7:0]  motion_axis_mask_control_q;
  reg [7:0]  motion_persist_timer_q;
  reg [7:0]  inactivity_count_q;
  reg [11:0] motion_level_threshold_q;

  // event state
  reg        drdy_flag_q;
  reg        motion_wake_flag_q;
  reg [5:0]  motion_direction_source_q;
  reg        motion_state_q;
  reg [7:0]  persist_cnt_q;
  reg [7:0]  inact_cnt_q;
  reg [25:0] rate_cnt_q;
  reg [9:0]  pulse_cnt_q;
  reg        pulse_on_q;

  reg        motion_state_d;
  reg        wake_fire;
  reg        inact_expire;
  reg [7:0]  persist_cnt_d;
  reg [7:0]  inact_cnt_d;

  // decoded controls
  wire data_ready_source_enable = main_control_one_q[`AIW_B_DRDY_EN];
  wire motion_wake_enable       = main_control_one_q[`AIW_B_WAKE_EN];
  wire pin_output_enable        = pin_interrupt_control_q[`AIW_B_PIN_EN];
  wire pin_active_polarity      = pin_interrupt_control_q[`AIW_B_POL];
  wire latch_or_pulse_select    = pin_interrupt_control_q[`AIW_B_PULSE];
  wire unlatched_motion_select  = motion_axis_mask_control_q[`AIW_B_UNLATCH];

  wire wr_hit_rel  = reg_rd_in && (reg_addr_in == `AIW_A_REL);

  // one motion sample period from the rate code
  function [25:0] rate_period;
    input [2:0] code;
    reg   [25:0] base;
    begin
      base        = MOTION_BASE_CYCLES[25:0];
      rate_period = base << (`AIW_RATE_MAX - code);
    end
  endfunction

  // {negative, positive} over-threshold for one axis
  function [1:0] axis_dir;
    input [11:0] a;
    input [11:0] thr;
    reg   signed [12:0] sa;
    reg   signed [12:0] st;
    begin
      sa       = {a[11], a};
      st       = {1'b0, thr};
      axis_dir = {(sa < -st), (sa > st)};
    end
  endfunction

  // motion sample tick; base period is the fastest rate
  wire [25:0] period_now = rate_period(main_control_two_q[`AIW_F_RATE]);
  wire        motion_tick = (rate_cnt_q >= period_now - 26'h0000001);

  always @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rate_cnt_q <= 26'h0000000;
    end else if (!motion_wake_enable || motion_tick) begin
      rate_cnt_q <= 26'h0000000;
    end else begin
      rate_cnt_q <= rate_cnt_q + 26'h0000001;
    end
  end

  // masked direction vector: x-, x+, y-, y+, z-, z+
  wire [5:0] dir_raw = {axis_dir(accel_x_in, motion_level_threshold_q),
                        axis_dir(accel_y_in, motion_level_threshold_q),
                        axis_dir(accel_z_in, motion_level_threshold_q)};
  wire [5:0] dir_hit = dir_raw & motion_axis_mask_control_q[`AIW_F_MASK];
  wire       moving  = |dir_hit;

  // motion engine
  always @* begin
    motion_state_d = motion_state_q;
    persist_cnt_d  = persist_cnt_q;
    inact_cnt_d    = inact_cnt_q;
    wake_fire      = 1'b0;
    inact_expire   = 1'b0;
    if (motion_tick) begin
      case (motion_state_q)
        ST_IDLE: begin
          if (moving) begin
            if (persist_cnt_q + 8'h01 >= motion_persist_timer_q) begin
              wake_fire      = 1'b1;
              motion_state_d = ST_ACTIVE;
              persist_cnt_d  = 8'h00;
              inact_cnt_d    = 8'h00;
            end else begin
              persist_cnt_d = persist_cnt_q + 8'h01;
            end
          end else begin
            persist_cnt_d = 8'h00; // must be consecutive samples
          end
        end
        ST_ACTIVE: begin
          if (moving) begin
            inact_cnt_d = 8'h00;
          end else if (inact_cnt_q + 8'h01 >= inactivity_count_q) begin
            inact_expire   = 1'b1;
            motion_state_d = ST_IDLE;
            inact_cnt_d    = 8'h00;
          end else begin
            inact_cnt_d = inact_cnt_q + 8'h01;
          end
        end
        default: begin
          motion_state_d = ST_IDLE;
          persist_cnt_d  = 8'h00;
          inact_cnt_d    = 8'h00;
        end
      endcase
    end
  end

  always @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      motion_state_q <= ST_IDLE;
      persist_cnt_q  <= 8'h00;
      inact_cnt_q    <= 8'h00;
    end else if (!motion_wake_enable) begin
      motion_state_q <= ST_IDLE;
      persist_cnt_q  <= 8'h00;
      inact_cnt_q    <= 8'h00;
    end else begin
      motion_state_q <= motion_state_d;
      persist_cnt_q  <= persist_cnt_d;
      inact_cnt_q    <= inact_cnt_d;
    end
  end

  // source flags; a new event beats a clearing read in the same cycle
  wire drdy_set = sample_valid_in && data_ready_source_enable;
  wire wake_set = wake_fire && motion_wake_enable;

  always @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      drdy_flag_q <= 1'b0;
    end else if (drdy_set) begin
      drdy_flag_q <= 1'b1;
    end else if (wr_hit_rel || accel_data_read_in) begin
      drdy_flag_q <= 1'b0;
    end
  end

  always @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      motion_wake_flag_q        <= 1'b0;
      motion_direction_source_q <= 6'h00;
    end else if (wake_set) begin
      motion_wake_flag_q        <= 1'b1;
      motion_direction_source_q <= dir_hit;
    end else begin
      if (wr_hit_rel) begin
        motion_wake_flag_q        <= 1'b0;
        motion_direction_source_q <= 6'h00;
      end else if (inact_expire && unlatched_motion_select) begin
        motion_wake_flag_q <= 1'b0;
      end
    end
  end

  // pending: enabled sources ored
  wire pending = (drdy_flag_q && data_ready_source_enable) ||
                 (motion_wake_flag_q && motion_wake_enable);

  // pulse shaper; restarts on each new event
  always @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pulse_on_q  <= 1'b0;
      pulse_cnt_q <= 10'h000;
    end else if (drdy_set || wake_set) begin
      pulse_on_q  <= 1'b1;
      pulse_cnt_q <= 10'h000;
    end else if (pulse_on_q) begin
      if (pulse_cnt_q >= `AIW_PULSE_CYC - 1) begin
        pulse_on_q <= 1'b0;
      end else begin
        pulse_cnt_q <= pulse_cnt_q + 10'h001;
      end
    end
  end

  // pin level; a pulse-mode interrupt does not hold the pin
  wire pin_active = pin_output_enable &&
                    (latch_or_pulse_select ? pulse_on_q : pending);

  always @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      int_pin_out <= 1'b0;
    end else begin
      int_pin_out <= pin_active_polarity ? pin_active : !pin_active;
    end
  end

  // register writes
  always @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      main_control_one_q         <= `AIW_R_CTRL_ONE;
      main_control_two_q         <= `AIW_R_CTRL_TWO;
      pin_interrupt_control_q    <= `AIW_R_PIN_CTL;
      motion_axis_mask_control_q <= `AIW_R_MASK_CTL;
      motion_persist_timer_q     <= `AIW_R_TIMER;
      inactivity_count_q         <= `AIW_R_INACT;
      motion_level_threshold_q   <= `AIW_R_THR;
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        `AIW_A_CTRL_ONE: begin
          main_control_one_q <= reg_wdata_in;
        end
        `AIW_A_CTRL_TWO: begin
          main_control_two_q <= reg_wdata_in;
        end
        `AIW_A_PIN_CTL: begin
          pin_interrupt_control_q <= reg_wdata_in;
        end
        `AIW_A_MASK_CTL: begin
          motion_axis_mask_control_q <= reg_wdata_in;
        end
        `AIW_A_TIMER: begin
          motion_persist_timer_q <= reg_wdata_in;
        end
        `AIW_A_INACT: begin
          inactivity_count_q <= reg_wdata_in;
        end
        `AIW_A_THR_HI: begin
          motion_level_threshold_q[11:4] <= reg_wdata_in;
        end
        `AIW_A_THR_LO: begin
          motion_level_threshold_q[3:0] <= reg_wdata_in[7:4];
        end
        default: begin
          main_control_one_q <= main_control_one_q;
        end
      endcase
    end
  end

  // read mux; unmapped and release read as zero
  reg [7:0] rd_mux;

  always @* begin
    rd_mux = 8'h00;
    case (reg_addr_in)
      `AIW_A_SRC_ONE: begin
        rd_mux[`AIW_B_SRC_DRDY] = drdy_flag_q;
        rd_mux[`AIW_B_SRC_WAKE] = motion_wake_flag_q;
      end
      `AIW_A_SRC_TWO: begin
        rd_mux = {2'b00, motion_direction_source_q};
      end
      `AIW_A_STATUS: begin
        rd_mux[`AIW_B_PEND] = pending;
      end
      `AIW_A_CTRL_ONE: begin
        rd_mux = main_control_one_q;
      end
      `AIW_A_CTRL_TWO: begin
        rd_mux = main_control_two_q;
      end
      `AIW_A_PIN_CTL: begin
        rd_mux = pin_interrupt_control_q;
      end
      `AIW_A_MASK_CTL: begin
        rd_mux = motion_axis_mask_control_q;
      end
      `AIW_A_TIMER: begin
        rd_mux = motion_persist_timer_q;
      end
      `AIW_A_INACT: begin
        rd_mux = inactivity_count_q;
      end
      `AIW_A_THR_HI: begin
        rd_mux = motion_level_threshold_q[11:4];
      end
      `AIW_A_THR_LO: begin
        rd_mux = {motion_level_threshold_q[3:0], 4'h0};
      end
      default: begin
        rd_mux = 8'h00;
      end
    endcase
  end

  // read data held until the next read strobe
  always @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      reg_rdata_out <= rd_mux;
    end
  end

endmodule

/* File: test/aiw_interrupt_wakeup_sva.sv */
// checker for the interrupt pin and the register port.
// assumes byte shadows of control writes track the design's registers.
`timescale 1ns/1ns
`include "aiw_defines.vh"
module aiw_interrupt_wakeup_sva (
  // clock, reset and register port
  input  wire       ref_clk_in,
  input  wire       rst_b_in,
  input  wire [7:0] reg_addr_in,
  input  wire [7:0] reg_wdata_in,
  input  wire       reg_wr_in,
  input  wire       reg_rd_in,
  input  wire [7:0] reg_rdata_out,
  // events and pin
  input  wire       sample_valid_in,
  input  wire       accel_data_read_in,
  input  wire       int_pin_out
);
  reg  [7:0] ctl_q;
  reg  [7:0] ctl_p_q;
  reg  [7:0] c1_q;
  reg  [7:0] mk_q;
  reg  [9:0] run_q;
  // pin flop lags the control register by one edge
  wire       act = (int_pin_out == ctl_p_q[`AIW_B_POL]);
  wire       rel = reg_rd_in && (reg_addr_in == `AIW_A_REL);
  wire       lat = ctl_q[5] && !ctl_q[3] && !mk_q[7];
  wire       wsel = reg_wr_in && (reg_addr_in == `AIW_A_PIN_CTL);
  always @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctl_q <= `AIW_R_PIN_CTL;
      ctl_p_q <= `AIW_R_PIN_CTL;
      c1_q  <= `AIW_R_CTRL_ONE;
      mk_q  <= `AIW_R_MASK_CTL;
      run_q <= 10'h000;
    end else begin
      ctl_q <= wsel ? reg_wdata_in : ctl_q;
      ctl_p_q <= ctl_q;
      c1_q  <= (reg_wr_in && reg_addr_in == `AIW_A_CTRL_ONE) ? reg_wdata_in : c1_q;
      mk_q  <= (reg_wr_in && reg_addr_in == `AIW_A_MASK_CTL) ? reg_wdata_in : mk_q;
      // counts active cycles, wraps harmlessly in latched mode
      run_q <= act ? run_q + 10'h001 : 10'h000;
    end
  end
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);
  sequence s_drdy;
    lat && c1_q[5] && sample_valid_in && !accel_data_read_in && !reg_wr_in
    ##1 !rel && !accel_data_read_in && !reg_wr_in;
  endsequence
  sequence s_clear;
    lat && (rel || accel_data_read_in) && !sample_valid_in && !c1_q[1]
    ##1 !sample_valid_in && !reg_wr_in;
  endsequence
  property p_pin_off;
    !ctl_q[5] && !$past(reg_wr_in) |-> int_pin_out == !ctl_q[4];
  endproperty
  property p_rel_zero;
    rel |=> reg_rdata_out == 8'h00;
  endproperty
  property p_status;
    reg_rd_in && reg_addr_in == `AIW_A_STATUS |=> (reg_rdata_out & 8'hEF) == 8'h00;
  endproperty
  property p_pulse;
    $fell(act) && ctl_q[5] && ctl_q[3] && $stable(ctl_q) |-> run_q == `AIW_PULSE_CYC;
  endproperty
  property p_hold;
    lat && act && !rel && !accel_data_read_in && !reg_wr_in && !$past(rel)
    && !$past(accel_data_read_in) && !$past(reg_wr_in) |=> act;
  endproperty
  property p_drdy;
    s_drdy |-> ##1 act;
  endproperty
  property p_clear;
    s_clear |-> ##1 !act;
  endproperty
  property p_off;
    !c1_q[5] && !c1_q[1] && !ctl_q[3] && !$past(reg_wr_in) && !$past(reg_wr_in, 2) |-> !act;
  endproperty
  a_pin_off:  assert property (p_pin_off) else $error("pin not idle while disabled");
  a_rel_zero: assert property (p_rel_zero) else $error("release read not zero");
  a_status:   assert property (p_status) else $error("status spare bits set");
  a_pulse:    assert property (p_pulse) else $error("pulse width wrong");
  a_hold:     assert property (p_hold) else $error("latched pin dropped");
  a_drdy:     assert property (p_drdy) else $error("data ready missed");
  a_clear:    assert property (p_clear) else $error("pin not cleared");
  a_off:      assert property (p_off) else $error("disabled source drove pin");
  c_drdy:     cover property (s_drdy);
endmodule

/* File: test/aiw_host_gpio.sv */
// host side model: a gpio input that counts rising pin edges.
// assumes the pin is sampled on the device clock, active high setup.
`timescale 1ns/1ns
module aiw_host_gpio (
  // pin from device
  input  wire    ref_clk_in,
  input  wire    int_pin_out,
  // edge count for the bench
  output integer hits_out
);
  reg last_q;
  initial begin
    hits_out = 0;
    last_q = 1'b0;
  end
  // isr only notes the event, no bus traffic from here
  always @(posedge ref_clk_in) begin
    if (int_pin_out === 1'b1 && last_q === 1'b0) begin
      hits_out <= hits_out + 1;
    end
    last_q <= int_pin_out;
  end
endmodule

/* File: test/aiw_interrupt_wakeup_test.sv */
// self-checking bench for the interrupt and wake-up logic.
// assumes motion ticks shortened by MOTION_BASE_CYCLES of 4.
`timescale 1ns/1ns
`include "aiw_defines.vh"
module aiw_interrupt_wakeup_test;
  reg         ref_clk_in, rst_b_in, reg_wr_in, reg_rd_in;
  reg         sample_valid_in, accel_data_read_in;
  reg  [7:0]  reg_addr_in, reg_wdata_in;
  reg  [11:0] accel_x_in, accel_y_in, accel_z_in;
  wire [7:0]  reg_rdata_out;
  wire        int_pin_out;
  integer     err_count, comparisons, hits, h0, cyc;
  reg  [15:0] rv;
  aiw_interrupt_wakeup #(.MOTION_BASE_CYCLES(4)) aiw_interrupt_wakeup_inst (.ref_clk_in,
    .rst_b_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
    .accel_x_in, .accel_y_in, .accel_z_in, .sample_valid_in, .accel_data_read_in,
    .int_pin_out);
  aiw_host_gpio aiw_host_gpio_inst (.ref_clk_in, .int_pin_out, .hits_out(hits));
  task close_out;
    begin
      $display("errors %0d comparisons %0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  task chk_val(input [15:0] e, input [15:0] g);
    begin
      comparisons = comparisons + 1;
      if (g !== e) begin
        err_count = err_count + 1;
        $display("[FAIL] %0t exp %h got %h", $time, e, g);
      end
    end
  endtask
  task chk_pin(input e);
    chk_val({15'h0000, e}, {15'h0000, int_pin_out});
  endtask
  task tick(input integer n);
    repeat (n) @(negedge ref_clk_in);
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(negedge ref_clk_in);
      reg_addr_in = a;
      reg_wdata_in = d;
      reg_wr_in = 1'b1;
      @(negedge ref_clk_in);
      reg_wr_in = 1'b0;
    end
  endtask
  task rd(input [7:0] a);
    begin
      @(negedge ref_clk_in);
      reg_addr_in = a;
      reg_rd_in = 1'b1;
      @(negedge ref_clk_in);
      reg_rd_in = 1'b0;
      rv = {8'h00, reg_rdata_out};
    end
  endtask
  task ev(input s, input d);
    begin
      @(negedge ref_clk_in);
      sample_valid_in = s;
      accel_data_read_in = d;
      @(negedge ref_clk_in);
      sample_valid_in = 1'b0;
      accel_data_read_in = 1'b0;
    end
  endtask
  // bounded wait; a miss ends the run
  task wait_pin(input v, input integer n);
    begin
      cyc = 0;
      while (int_pin_out !== v && cyc < n) begin
        @(negedge ref_clk_in);
        cyc = cyc + 1;
      end
      if (int_pin_out !== v) begin
        err_count = err_count + 1;
        $display("[FAIL] %0t exp %h got %h", $time, v, int_pin_out);
        close_out;
      end
    end
  endtask
  task t_reset;
    begin
      chk_pin(1'b0);
      rd(`AIW_A_PIN_CTL);
      chk_val(16'h0010, rv);
      rd(`AIW_A_MASK_CTL);
      chk_val(16'h003F, rv);
      rd(`AIW_A_CTRL_ONE);
      chk_val(16'h0000, rv);
      rd(8'h55);
      chk_val(16'h0000, rv);
      wr(`AIW_A_SRC_TWO, 8'h3F);
      rd(`AIW_A_SRC_TWO);
      chk_val(16'h0000, rv);
    end
  endtask
  task t_drdy;
    begin
      rd(`AIW_A_REL);
      wr(`AIW_A_PIN_CTL, 8'h30);
      ev(1'b1, 1'b0);
      tick(2);
      chk_pin(1'b0);
      wr(`AIW_A_CTRL_ONE, 8'h20);
      ev(1'b1, 1'b0);
      tick(2);
      chk_pin(1'b1);
      rd(`AIW_A_STATUS);
      chk_val(16'h0010, rv);
      rd(`AIW_A_SRC_ONE);
      chk_val(16'h0010, rv);
      tick(20);
      chk_pin(1'b1);
      ev(1'b0, 1'b1);
      tick(2);
      chk_pin(1'b0);
      ev(1'b1, 1'b0);
      rd(`AIW_A_REL);
      tick(1);
      chk_pin(1'b0);
      wr(`AIW_A_PIN_CTL, 8'h20);
      tick(2);
      chk_pin(1'b1);
      ev(1'b1, 1'b0);
      tick(2);
      chk_pin(1'b0);
      wr(`AIW_A_PIN_CTL, 8'h00);
      ev(1'b1, 1'b0);
      tick(2);
      chk_pin(1'b1);
      rd(`AIW_A_REL);
    end
  endtask
  task t_pulse;
    begin
      // pulses start in any mode; let one left from latched events lapse
      tick(`AIW_PULSE_CYC);
      wr(`AIW_A_PIN_CTL, 8'h38);
      h0 = hits;
      ev(1'b1, 1'b0);
      wait_pin(1'b1, 5);
      wait_pin(1'b0, 900);
      chk_val(`AIW_PULSE_CYC, cyc[15:0]);
      chk_val(h0 + 1, hits[15:0]);
      wr(`AIW_A_CTRL_ONE, 8'h00);
      rd(`AIW_A_REL);
    end
  endtask
  // rate 6 gives one motion sample every 8 cycles, timer 3 samples
  task t_wake;
    begin
      wr(`AIW_A_CTRL_TWO, 8'h06);
      wr(`AIW_A_TIMER, 8'h03);
      wr(`AIW_A_INACT, 8'h02);
      wr(`AIW_A_THR_HI, 8'h01);
      wr(`AIW_A_THR_LO, 8'h00);
      wr(`AIW_A_PIN_CTL, 8'h30);
      wr(`AIW_A_CTRL_ONE, 8'h02);
      tick(30);
      accel_x_in = 12'h014;
      tick(14);
      chk_pin(1'b0);
      wait_pin(1'b1, 30);
      rd(`AIW_A_SRC_TWO);
      chk_val(16'h0010, rv);
      rd(`AIW_A_SRC_ONE);
      chk_val(16'h0002, rv);
      rd(`AIW_A_REL);
      tick(40);
      chk_pin(1'b0);
      rd(`AIW_A_SRC_TWO);
      chk_val(16'h0000, rv);
      accel_x_in = 12'h010;
      tick(50);
      chk_pin(1'b0);
      wr(`AIW_A_MASK_CTL, 8'h2F);
      accel_x_in = 12'h014;
      tick(50);
      chk_pin(1'b0);
      accel_x_in = 12'hFEC;
      wait_pin(1'b1, 40);
      rd(`AIW_A_SRC_TWO);
      chk_val(16'h0020, rv);
      rd(`AIW_A_REL);
      accel_x_in = 12'h000;
      wr(`AIW_A_MASK_CTL, 8'hBF);
      tick(30);
      accel_x_in = 12'h014;
      wait_pin(1'b1, 40);
      accel_x_in = 12'h000;
      wait_pin(1'b0, 40);
      chk_pin(1'b0);
      accel_y_in = 12'h014;
      accel_z_in = 12'hFEC;
      wait_pin(1'b1, 40);
      rd(`AIW_A_SRC_TWO);
      chk_val(16'h0006, rv);
      {accel_y_in, accel_z_in} = 24'h000000;
      rd(`AIW_A_REL);
    end
  endtask
  initial begin
    ref_clk_in = 1'b0;
    forever #25 ref_clk_in = ~ref_clk_in;
  end
  initial begin
    {rst_b_in, reg_wr_in, reg_rd_in, sample_valid_in, accel_data_read_in} = 5'h00;
    {reg_addr_in, reg_wdata_in} = 16'h0000;
    {accel_x_in, accel_y_in, accel_z_in} = 36'h000000000;
    err_count = 0;
    comparisons = 0;
    tick(20);
    rst_b_in = 1'b1;
    t_reset;
    t_drdy;
    t_pulse;
    t_wake;
    close_out;
  end
endmodule
bind aiw_interrupt_wakeup aiw_interrupt_wakeup_sva aiw_interrupt_wakeup_sva_inst (.ref_clk_in,
  .rst_b_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
  .sample_valid_in, .accel_data_read_in, .int_pin_out);
